/* spcr_pkg.sv */
// Constants, register map and reset values for the port configuration bank.
// Notes on behaviour
// - Bit 0 activates each device; upper bits reserved
// - Printer base 100h-FFCh, 4-byte aligned, no EPP
// - EPP allowed only on 8-byte aligned base
// - Printer interrupt line select, bits 3-0
// - Printer DMA channel 0-3, 1xx disables DMA
// - Printer threshold bits 6-3, mode bits 2-0
// - Printer mode encodings SPP, EPP, ECP variants
// - UART base 100h-FF8h, 8-byte aligned, resets given
// - UART interrupt line select, bits 3-0
// - UART bit 7 clear delays receive sample clock
// - UART bit 6 picks level or pulse interrupt
// - UART bit 5 picks receive FIFO error signal
// - Clock codes 00 divide 13, 01 divide 12
// - UART B bit 3: 40 bit-time receive hold-off
// - UART B bit 2: 40 bit-time transmit delay
package spcr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
  localparam logic [7:0] IDX_DMA_SELECT = 8'h74;
  localparam logic [7:0] IDX_OPTIONS = 8'hf0;
  // Bank-zero control registers
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h00;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h01;
  localparam logic [7:0] IDX_GLOBAL_OPTION = 8'h02;
  localparam logic [7:0] IDX_BLOCK_STATE = 8'h03;
  // Bank codes in haddr[11:10]
  localparam logic [1:0] BANK_CTRL = 2'h0;
  localparam logic [1:0] BANK_PRINTER = 2'h1;
  localparam logic [1:0] BANK_UART_A = 2'h2;
  localparam logic [1:0] BANK_UART_B = 2'h3;
  // Device slot numbers in the register arrays
  localparam int DEV_PRINTER = 0;
  localparam int DEV_UART_A = 1;
  localparam int DEV_UART_B = 2;
  localparam int NUM_DEV = 3;
  // Reset values per slot
  localparam logic [7:0] RST_ACTIVATE [NUM_DEV] = '{8'h01, 8'h01, 8'h01};
  localparam logic [7:0] RST_BASE_HIGH [NUM_DEV] = '{8'h03, 8'h03, 8'h02};
  localparam logic [7:0] RST_BASE_LOW [NUM_DEV] = '{8'h78, 8'hf8, 8'hf8};
  localparam logic [7:0] RST_IRQ_SELECT [NUM_DEV] = '{8'h07, 8'h04, 8'h03};
  localparam logic [7:0] RST_OPTIONS [NUM_DEV] = '{8'h3f, 8'h00, 8'h00};
  localparam logic [7:0] RST_DMA_SELECT = 8'h04;
  localparam logic [7:0] RST_GLOBAL_OPTION = 8'h00;
  localparam logic [3:0] RST_EVENT_MASK = 4'h0;
  // Writable bit masks; others reserved, read zero
  localparam logic [7:0] WMASK_ACTIVATE = 8'h01;
  localparam logic [7:0] WMASK_IRQ_SELECT = 8'h0f;
  localparam logic [7:0] WMASK_DMA_SELECT = 8'h07;
  localparam logic [7:0] WMASK_PRINTER_OPT = 8'h7f;
  localparam logic [7:0] WMASK_UART_A_OPT = 8'he3;
  localparam logic [7:0] WMASK_UART_B_OPT = 8'hef;
  localparam logic [7:0] WMASK_GLOBAL_OPTION = 8'h04;
  // Field positions
  localparam int POS_EXT_MODE = 2;
  localparam int POS_RX_NO_DELAY = 7;
  localparam int POS_IRQ_PULSE = 6;
  localparam int POS_NEW_FIFO_ERR = 5;
  localparam int POS_RX_HOLDOFF = 3;
  localparam int POS_TX_HOLDOFF = 2;
  // Base address windows
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX_4 = 16'h0ffc;
  localparam logic [15:0] BASE_MAX_8 = 16'h0ff8;
  // Infrared turnaround length in bit-times
  localparam logic [5:0] HOLD_BIT_TIMES = 6'd40;
  // Receive sample clock delay when bit 7 is clear
  localparam int RX_DELAY_NS = 5;
  // Event status bit positions
  localparam int EV_EPP_DROPPED = 0;
  localparam int EV_BAD_BASE = 1;
  localparam int EV_RX_HOLD_DONE = 2;
  localparam int EV_TX_HOLD_DONE = 3;
  localparam int NUM_EV = 4;
endpackage

/* spcr_regs.sv */
// Port configuration register bank with AHB-Lite slave and infrared turnaround timers.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module spcr_regs
  import spcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt to host
  output logic irq,
  // Infrared link status from UART B
  input wire logic sir_tx_mode,
  input wire logic uart_b_bit_tick,
  // Printer port configuration
  output logic printer_port_active,
  output logic [15:0] printer_port_base,
  output logic printer_port_base_ok,
  output logic printer_port_epp_ok,
  output logic [3:0] printer_port_irq_line,
  output logic printer_port_dma_en,
  output logic [1:0] printer_port_dma_chan,
  output logic [3:0] printer_port_fifo_thresh,
  output logic [2:0] printer_port_mode,
  output logic printer_port_mode_applies,
  // UART configuration, index 0 is UART A, 1 is UART B
  output logic [1:0] uart_active,
  output logic [31:0] uart_base,
  output logic [1:0] uart_base_ok,
  output logic [7:0] uart_irq_line,
  output logic [1:0] uart_rx_clk_delay,
  output logic [1:0] uart_irq_pulse,
  output logic [1:0] uart_new_fifo_err,
  output logic [3:0] uart_clk_sel,
  // Infrared turnaround holds for UART B
  output logic ir_rx_hold,
  output logic ir_tx_hold
);

  // Base check shared by all three devices
  // need8 picks the eight-byte window; otherwise the four-byte one applies
  // An illegal base is still stored, so software can read back what it wrote
  function automatic logic base_fits(input logic [15:0] b, input logic need8);
    base_fits = (b >= BASE_MIN) && (need8 ? (b <= BASE_MAX_8) && (b[2:0] == 3'h0)
                                          : (b <= BASE_MAX_4) && (b[1:0] == 2'h0));
  endfunction

  // Configuration storage per device slot
  logic [7:0] act_reg [NUM_DEV];
  logic [7:0] bhi_reg [NUM_DEV];
  logic [7:0] blo_reg [NUM_DEV];
  logic [7:0] irqsel_reg [NUM_DEV];
  logic [7:0] opt_reg [NUM_DEV];
  logic [7:0] dma_reg;
  logic [7:0] gopt_reg;
  logic [NUM_EV-1:0] evstat_reg;
  logic [NUM_EV-1:0] evmask_reg;

  // Latched address phase
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [1:0] dp_bank_reg;
  logic [7:0] dp_idx_reg;
  logic rd_pend_reg;
  // Write data phase seen last cycle; base checks then see the new value
  logic wr_done_reg;

  // Bus phase decode
  // hsize is ignored: every register is one aligned word in bits 7:0
  wire addr_take = hsel & htrans[1] & hready;
  wire wr_now = dp_valid_reg & dp_write_reg;
  wire [7:0] wbyte = hwdata[7:0];

  // Write strobes per slot, derived from the latched bank
  logic [NUM_DEV-1:0] wr_dev;
  assign wr_dev[DEV_PRINTER] = wr_now & (dp_bank_reg == BANK_PRINTER);
  assign wr_dev[DEV_UART_A] = wr_now & (dp_bank_reg == BANK_UART_A);
  assign wr_dev[DEV_UART_B] = wr_now & (dp_bank_reg == BANK_UART_B);
  wire wr_ctrl = wr_now & (dp_bank_reg == BANK_CTRL);

  // Option write masks per slot
  logic [7:0] opt_wmask [NUM_DEV];
  assign opt_wmask[DEV_PRINTER] = WMASK_PRINTER_OPT;
  assign opt_wmask[DEV_UART_A] = WMASK_UART_A_OPT;
  assign opt_wmask[DEV_UART_B] = WMASK_UART_B_OPT;

  // Register slices per slot
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DEV; gd++) begin : g_dev
      // Activation, base, interrupt line and options
      // Each slot has its own reset set, so one loop serves all three devices
      always_ff @(posedge core_clk) begin
        if (rst) begin
          act_reg[gd] <= RST_ACTIVATE[gd];
          bhi_reg[gd] <= RST_BASE_HIGH[gd];
          blo_reg[gd] <= RST_BASE_LOW[gd];
          irqsel_reg[gd] <= RST_IRQ_SELECT[gd];
          opt_reg[gd] <= RST_OPTIONS[gd];
        end else if (wr_dev[gd]) begin
          if (dp_idx_reg == IDX_ACTIVATE) act_reg[gd] <= wbyte & WMASK_ACTIVATE;
          if (dp_idx_reg == IDX_BASE_HIGH) bhi_reg[gd] <= wbyte;
          if (dp_idx_reg == IDX_BASE_LOW) blo_reg[gd] <= wbyte;
          if (dp_idx_reg == IDX_IRQ_SELECT) irqsel_reg[gd] <= wbyte & WMASK_IRQ_SELECT;
          if (dp_idx_reg == IDX_OPTIONS) opt_reg[gd] <= wbyte & opt_wmask[gd];
        end
      end
    end
  endgenerate

  // Printer DMA, global option and event mask registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dma_reg <= RST_DMA_SELECT;
      gopt_reg <= RST_GLOBAL_OPTION;
      evmask_reg <= RST_EVENT_MASK;
    end else begin
      if (wr_dev[DEV_PRINTER] && dp_idx_reg == IDX_DMA_SELECT) dma_reg <= wbyte & WMASK_DMA_SELECT;
      if (wr_ctrl && dp_idx_reg == IDX_GLOBAL_OPTION) gopt_reg <= wbyte & WMASK_GLOBAL_OPTION;
      if (wr_ctrl && dp_idx_reg == IDX_EVENT_MASK) evmask_reg <= wbyte[NUM_EV-1:0];
    end
  end

  // Assembled base addresses
  wire [15:0] prt_base = {bhi_reg[DEV_PRINTER], blo_reg[DEV_PRINTER]};
  wire [15:0] ua_base = {bhi_reg[DEV_UART_A], blo_reg[DEV_UART_A]};
  wire [15:0] ub_base = {bhi_reg[DEV_UART_B], blo_reg[DEV_UART_B]};
  wire prt_ok = base_fits(prt_base, 1'b0);
  wire prt_epp = base_fits(prt_base, 1'b1);
  wire ua_ok = base_fits(ua_base, 1'b1);
  wire ub_ok = base_fits(ub_base, 1'b1);

  // Mode with EPP stripped when the base cannot carry it
  // The stored field keeps what software wrote; only the output is stripped
  wire [2:0] mode_field = opt_reg[DEV_PRINTER][2:0];
  // odd codes carry EPP; drop to SPP or ECP
  wire epp_drop = mode_field[0] & ~prt_epp;
  wire [2:0] mode_eff = epp_drop ? {1'b0, mode_field[1], 1'b0} : mode_field;
  // mode applies while extended select clear
  wire mode_applies = ~gopt_reg[POS_EXT_MODE];

  // Infrared direction synchroniser; first stage feeds only the second
  // Reset level is receive; a pin idling in transmit gives one turnaround after reset
  logic sir_meta_reg;
  logic sir_sync_reg;
  logic sir_prev_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sir_meta_reg <= 1'b0;
      sir_sync_reg <= 1'b0;
      sir_prev_reg <= 1'b0;
    end else begin
      sir_meta_reg <= sir_tx_mode;
      sir_sync_reg <= sir_meta_reg;
      sir_prev_reg <= sir_sync_reg;
    end
  end
  wire to_rx = sir_prev_reg & ~sir_sync_reg;
  wire to_tx = ~sir_prev_reg & sir_sync_reg;

  // Turnaround counters, counting UART B bit ticks
  // A new turnaround reloads the count, so a quick reversal restarts the hold
  // Six bits cover the 40 bit-time hold with room to spare
  logic [5:0] rx_cnt_reg;
  logic [5:0] tx_cnt_reg;
  logic [5:0] rx_cnt_next;
  logic [5:0] tx_cnt_next;
  assign rx_cnt_next = (to_rx && opt_reg[DEV_UART_B][POS_RX_HOLDOFF]) ? HOLD_BIT_TIMES :
                       (rx_cnt_reg != 6'd0 && uart_b_bit_tick) ? rx_cnt_reg - 6'd1 : rx_cnt_reg;
  assign tx_cnt_next = (to_tx && opt_reg[DEV_UART_B][POS_TX_HOLDOFF]) ? HOLD_BIT_TIMES :
                       (tx_cnt_reg != 6'd0 && uart_b_bit_tick) ? tx_cnt_reg - 6'd1 : tx_cnt_reg;
  wire rx_done = (rx_cnt_reg == 6'd1) && (rx_cnt_next == 6'd0);
  wire tx_done = (tx_cnt_reg == 6'd1) && (tx_cnt_next == 6'd0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_cnt_reg <= 6'd0;
      tx_cnt_reg <= 6'd0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  // Event sources; bad base flags any window the device cannot use
  logic [NUM_EV-1:0] ev_set;
  assign ev_set[EV_EPP_DROPPED] = epp_drop & mode_applies & wr_dev[DEV_PRINTER];
  // Judged one cycle after the write, so the write that breaks a base is flagged
  assign ev_set[EV_BAD_BASE] = wr_done_reg & ~(prt_ok & ua_ok & ub_ok);
  assign ev_set[EV_RX_HOLD_DONE] = rx_done;
  assign ev_set[EV_TX_HOLD_DONE] = tx_done;
  wire [NUM_EV-1:0] ev_clr = (wr_ctrl && dp_idx_reg == IDX_EVENT_STATUS) ? wbyte[NUM_EV-1:0] : '0;

  // Sticky status: a new event wins over a same-cycle clear
  // Software clears a bit by writing one to it; zeros leave bits alone
  always_ff @(posedge core_clk) begin
    if (rst) evstat_reg <= '0;
    else evstat_reg <= (evstat_reg & ~ev_clr) | ev_set;
  end

  // Read selection, taken in the read wait cycle
  // Unmapped indices and reserved bits read as zero
  // The DMA register exists only in the printer bank
  logic [7:0] rd_sel;
  wire [1:0] slot = (dp_bank_reg == BANK_UART_A) ? 2'd1 : (dp_bank_reg == BANK_UART_B) ? 2'd2 : 2'd0;
  always_comb begin
    rd_sel = 8'h00;
    if (dp_bank_reg == BANK_CTRL) begin
      case (dp_idx_reg)
        IDX_EVENT_STATUS: rd_sel = {4'h0, evstat_reg};
        IDX_EVENT_MASK: rd_sel = {4'h0, evmask_reg};
        IDX_GLOBAL_OPTION: rd_sel = gopt_reg;
        IDX_BLOCK_STATE: rd_sel = {2'b00, ir_tx_hold, ir_rx_hold, ub_ok, ua_ok, prt_epp, prt_ok};
        default: rd_sel = 8'h00;
      endcase
    end else begin
      case (dp_idx_reg)
        IDX_ACTIVATE: rd_sel = act_reg[slot];
        IDX_BASE_HIGH: rd_sel = bhi_reg[slot];
        IDX_BASE_LOW: rd_sel = blo_reg[slot];
        IDX_IRQ_SELECT: rd_sel = irqsel_reg[slot];
        IDX_DMA_SELECT: rd_sel = (dp_bank_reg == BANK_PRINTER) ? dma_reg : 8'h00;
        IDX_OPTIONS: rd_sel = opt_reg[slot];
        default: rd_sel = 8'h00;
      endcase
    end
  end

  // Bus phase tracking; reads take one wait cycle so a prior write is seen
  // Writes finish with no wait; the slave always answers OKAY
  // The wait costs read bandwidth but keeps the read mux off the address path
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_bank_reg <= 2'h0;
      dp_idx_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      wr_done_reg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      if (hready) begin
        dp_valid_reg <= addr_take;
        dp_write_reg <= hwrite;
        dp_bank_reg <= haddr[11:10];
        dp_idx_reg <= haddr[9:2];
      end else begin
        dp_valid_reg <= dp_valid_reg;
      end
      rd_pend_reg <= addr_take & ~hwrite;
      wr_done_reg <= wr_now;
      hreadyout <= ~(addr_take & ~hwrite);
      // Read data is captured in the wait cycle
      if (rd_pend_reg) hrdata <= {24'h00_0000, rd_sel};
      hresp <= 1'b0;
    end
  end

  // Registered configuration outputs
  // Each output except irq and the ir holds is one flop behind its register, so it moves one edge after the write
  // Outputs read zero during reset and show register values from the first edge after
  always_ff @(posedge core_clk) begin
    if (rst) begin
      printer_port_active <= 1'b0;
      printer_port_base <= 16'h0000;
      printer_port_base_ok <= 1'b0;
      printer_port_epp_ok <= 1'b0;
      printer_port_irq_line <= 4'h0;
      printer_port_dma_en <= 1'b0;
      printer_port_dma_chan <= 2'h0;
      printer_port_fifo_thresh <= 4'h0;
      printer_port_mode <= 3'h0;
      printer_port_mode_applies <= 1'b0;
      uart_active <= 2'b00;
      uart_base <= 32'h0000_0000;
      uart_base_ok <= 2'b00;
      uart_irq_line <= 8'h00;
      uart_rx_clk_delay <= 2'b00;
      uart_irq_pulse <= 2'b00;
      uart_new_fifo_err <= 2'b00;
      uart_clk_sel <= 4'h0;
      ir_rx_hold <= 1'b0;
      ir_tx_hold <= 1'b0;
      irq <= 1'b0;
    end else begin
      printer_port_active <= act_reg[DEV_PRINTER][0];
      uart_active <= {act_reg[DEV_UART_B][0], act_reg[DEV_UART_A][0]};
      printer_port_base <= prt_base;
      printer_port_base_ok <= prt_ok;
      printer_port_epp_ok <= prt_epp;
      printer_port_irq_line <= irqsel_reg[DEV_PRINTER][3:0];
      printer_port_dma_en <= ~dma_reg[2];
      printer_port_dma_chan <= dma_reg[1:0];
      printer_port_fifo_thresh <= opt_reg[DEV_PRINTER][6:3];
      printer_port_mode <= mode_eff;
      printer_port_mode_applies <= mode_applies;
      uart_base <= {ub_base, ua_base};
      uart_base_ok <= {ub_ok, ua_ok};
      uart_irq_line <= {irqsel_reg[DEV_UART_B][3:0], irqsel_reg[DEV_UART_A][3:0]};
      uart_rx_clk_delay <= {~opt_reg[DEV_UART_B][POS_RX_NO_DELAY], ~opt_reg[DEV_UART_A][POS_RX_NO_DELAY]};
      uart_irq_pulse <= {opt_reg[DEV_UART_B][POS_IRQ_PULSE], opt_reg[DEV_UART_A][POS_IRQ_PULSE]};
      uart_new_fifo_err <= {opt_reg[DEV_UART_B][POS_NEW_FIFO_ERR], opt_reg[DEV_UART_A][POS_NEW_FIFO_ERR]};
      // divisor code passed to clock generator
      uart_clk_sel <= {opt_reg[DEV_UART_B][1:0], opt_reg[DEV_UART_A][1:0]};
      ir_rx_hold <= (rx_cnt_next != 6'd0);
      ir_tx_hold <= (tx_cnt_next != 6'd0);
      // Interrupt follows the next status value, so it rises with the event
      irq <= |(((evstat_reg & ~ev_clr) | ev_set) & evmask_reg);
    end
  end

endmodule // spcr_regs

/* spcr_regs_chk.sv */
// Concurrent checks on the port configuration bank, bound to its top module.
`timescale 1ns/1ps
module spcr_regs_chk
  import spcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus side
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Configuration outputs
  input wire logic [15:0] printer_port_base,
  input wire logic printer_port_base_ok,
  input wire logic printer_port_epp_ok,
  input wire logic [2:0] printer_port_mode,
  input wire logic [31:0] uart_base,
  input wire logic [1:0] uart_base_ok,
  // Infrared turnaround
  input wire logic uart_b_bit_tick,
  input wire logic ir_rx_hold,
  input wire logic ir_tx_hold
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Base windows written out by hand so a wrong package constant is caught
  function automatic logic ok4(input logic [15:0] b);
    return b >= 16'h0100 && b <= 16'h0ffc && b[1:0] == 2'h0;
  endfunction
  function automatic logic ok8(input logic [15:0] b);
    return b >= 16'h0100 && b <= 16'h0ff8 && b[2:0] == 3'h0;
  endfunction
  // Accepted transfers
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  wire wr_take = hsel && htrans[1] && hready && hwrite;
  // Reads get exactly one wait, writes none
  chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
  chk_write_nowait: assert property (wr_take |=> hreadyout) else $error("write stalled");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  chk_rdata_upper: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_prt_base_ok: assert property (printer_port_base_ok == ok4(printer_port_base))
    else $error("printer base flag wrong");
  chk_prt_epp_ok: assert property (printer_port_epp_ok == ok8(printer_port_base))
    else $error("printer epp flag wrong");
  chk_mode_strip: assert property (!printer_port_epp_ok |-> !printer_port_mode[0])
    else $error("epp mode not stripped");
  chk_uart_base_ok: assert property (uart_base_ok == {ok8(uart_base[31:16]), ok8(uart_base[15:0])})
    else $error("uart base flag wrong");
  // A hold may only end on a bit-time tick
  chk_rx_hold_end: assert property ($fell(ir_rx_hold) |-> $past(uart_b_bit_tick))
    else $error("rx hold ended off tick");
  chk_tx_hold_end: assert property ($fell(ir_tx_hold) |-> $past(uart_b_bit_tick))
    else $error("tx hold ended off tick");
  // Main scenarios reached
  cov_read: cover property (rd_take ##2 hreadyout);
  cov_rx_hold: cover property ($rose(ir_rx_hold));
  cov_tx_hold: cover property ($rose(ir_tx_hold));
endmodule // spcr_regs_chk
bind spcr_regs spcr_regs_chk u_chk (.*);

/* spcr_regs_test.sv */
// Self-checking bench for the port configuration register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module spcr_regs_test
  import spcr_pkg::*;
;
  // Stimulus
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, sir_tx_mode = 0, uart_b_bit_tick = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, uart_base;
  logic [1:0] htrans = 0, tdiv = 0;
  logic [2:0] hsize = 3'h2;
  // Observed outputs
  logic hready, hreadyout, hresp, irq, printer_port_active, printer_port_base_ok, printer_port_epp_ok;
  logic printer_port_dma_en, printer_port_mode_applies, ir_rx_hold, ir_tx_hold;
  logic [15:0] printer_port_base;
  logic [3:0] printer_port_irq_line, printer_port_fifo_thresh, uart_clk_sel;
  logic [1:0] printer_port_dma_chan, uart_active, uart_base_ok, uart_rx_clk_delay, uart_irq_pulse, uart_new_fifo_err;
  logic [2:0] printer_port_mode;
  logic [7:0] uart_irq_line, d;
  int errors = 0, n_checks = 0, cyc = 0;
  // Indices, reset values and writable masks per device
  logic [7:0] ix [5] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hf0};
  logic [7:0] rv [3][5] = '{'{8'h01, 8'h03, 8'h78, 8'h07, 8'h3f}, '{8'h01, 8'h03, 8'hf8, 8'h04, 8'h00},
    '{8'h01, 8'h02, 8'hf8, 8'h03, 8'h00}};
  logic [7:0] wm [3][5] = '{'{8'h01, 8'hff, 8'hff, 8'h0f, 8'h7f}, '{8'h01, 8'hff, 8'hff, 8'h0f, 8'he3},
    '{8'h01, 8'hff, 8'hff, 8'h0f, 8'hef}};
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  spcr_regs dut (.*);
  initial forever #10 core_clk = ~core_clk;
  // Bit-time tick every fourth cycle keeps the 40 bit-time holds short
  always @(posedge core_clk) begin
    tdiv <= tdiv + 2'h1;
    uart_b_bit_tick <= (tdiv == 2'h3);
  end
  // Hang guard, far above the expected thousand or so cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Single AHB transfer; writes wait two more edges so outputs have landed
  task automatic xfer(input logic w, input logic [1:0] b, input logic [7:0] i, input logic [7:0] v);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, b, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do @(posedge core_clk); while (hready !== 1'b1);
    d = hrdata[7:0];
    if (w) repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] b, input logic [7:0] i, input logic [7:0] v); xfer(1'b1, b, i, v); endtask
  task automatic rd(input logic [1:0] b, input logic [7:0] i); xfer(1'b0, b, i, 8'h00); endtask
  task automatic t_reset;
    for (int dv = 0; dv < 3; dv++) for (int k = 0; k < 5; k++) begin
      rd(2'(dv + 1), ix[k]);
      `CHK(d, rv[dv][k])
    end
    rd(2'h1, 8'h74);
    `CHK(d, 8'h04)
    `CHK(uart_base, 32'h02f8_03f8)
    `CHK(printer_port_base, 16'h0378)
  endtask
  // Reserved bits read zero, option fields reach their outputs
  task automatic t_masks;
    for (int dv = 0; dv < 3; dv++) for (int k = 0; k < 5; k++) begin
      wr(2'(dv + 1), ix[k], 8'hff);
      rd(2'(dv + 1), ix[k]);
      `CHK(d, wm[dv][k])
    end
    `CHK({uart_active, printer_port_active}, 3'h7)
    `CHK(printer_port_irq_line, 4'hf)
    `CHK(uart_irq_line, 8'hff)
    `CHK(printer_port_fifo_thresh, 4'hf)
    `CHK(uart_rx_clk_delay, 2'h0)
    `CHK(uart_irq_pulse, 2'h3)
    `CHK(uart_new_fifo_err, 2'h3)
    wr(2'h2, 8'hf0, 8'h00);
    wr(2'h2, 8'h30, 8'h00);
    `CHK(uart_rx_clk_delay, 2'h1)
    `CHK({uart_irq_pulse, uart_new_fifo_err}, 4'ha)
    `CHK(uart_active, 2'h2)
    wr(2'h0, 8'h10, 8'hff);
    rd(2'h0, 8'h10);
    `CHK(d, 8'h00)
  endtask
  task automatic t_dma_clk;
    for (int c = 0; c < 8; c++) begin
      wr(2'h1, 8'h74, 8'(c));
      `CHK({printer_port_dma_en, printer_port_dma_chan}, {~c[2], c[1:0]})
    end
    for (int c = 0; c < 4; c++) begin
      wr(2'h3, 8'hf0, 8'(c));
      `CHK(uart_clk_sel[3:2], 2'(c))
    end
  endtask
  task automatic t_base;
    wr(2'h1, 8'h60, 8'h01);
    wr(2'h1, 8'h61, 8'h08);
    `CHK(printer_port_epp_ok, 1'b1)
    for (int m = 0; m < 8; m++) begin
      wr(2'h1, 8'hf0, 8'(m));
      `CHK(printer_port_mode, 3'(m))
    end
    `CHK(printer_port_mode_applies, 1'b1)
    wr(2'h0, 8'h02, 8'h04);
    `CHK(printer_port_mode_applies, 1'b0)
    wr(2'h0, 8'h02, 8'h00);
    wr(2'h1, 8'h61, 8'h04);
    `CHK({printer_port_base_ok, printer_port_epp_ok}, 2'h2)
    wr(2'h1, 8'hf0, 8'h01);
    `CHK(printer_port_mode, 3'h0)
    wr(2'h1, 8'h60, 8'h00);
    `CHK(printer_port_base_ok, 1'b0)
    wr(2'h1, 8'h60, 8'h01);
    wr(2'h2, 8'h60, 8'h01);
    wr(2'h2, 8'h61, 8'hfc);
    `CHK(uart_base_ok[0], 1'b0)
    wr(2'h2, 8'h61, 8'hf8);
    wr(2'h3, 8'h61, 8'hf8);
    wr(2'h3, 8'h60, 8'h01);
    `CHK(uart_base, 32'h01f8_01f8)
  endtask
  // Bad base event raised, masked and cleared
  task automatic t_irq;
    wr(2'h0, 8'h00, 8'h0f);
    wr(2'h0, 8'h01, 8'h02);
    `CHK(irq, 1'b0)
    wr(2'h1, 8'h60, 8'h00);
    `CHK(irq, 1'b1)
    wr(2'h0, 8'h01, 8'h00);
    `CHK(irq, 1'b0)
    wr(2'h1, 8'h60, 8'h01);
    wr(2'h0, 8'h01, 8'h02);
    `CHK(irq, 1'b1)
    wr(2'h0, 8'h00, 8'h02);
    `CHK(irq, 1'b0)
    rd(2'h0, 8'h00);
    `CHK(d, 8'h01)
  endtask
  // Turnaround: none with the enable clear, else exactly 40 ticks
  task automatic t_ir(input logic tx);
    int n;
    int w;
    n = 0;
    w = 0;
    wr(2'h3, 8'hf0, 8'h00);
    @(posedge core_clk);
    sir_tx_mode <= ~tx;
    repeat (10) @(posedge core_clk);
    `CHK({ir_tx_hold, ir_rx_hold}, 2'h0)
    wr(2'h3, 8'hf0, tx ? 8'h04 : 8'h08);
    @(posedge core_clk);
    sir_tx_mode <= tx;
    // Hold and tick are read just after each edge, once settled
    do begin @(posedge core_clk); #1; w++; end while ((tx ? ir_tx_hold : ir_rx_hold) !== 1'b1 && w < 20);
    while ((tx ? ir_tx_hold : ir_rx_hold) === 1'b1 && w < 400) begin
      if (uart_b_bit_tick === 1'b1) n++;
      @(posedge core_clk);
      #1;
      w++;
    end
    `CHK(n, 40)
    rd(2'h0, 8'h00);
    `CHK(d[2 + tx], 1'b1)
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    $display("reset values done");
    t_masks();
    $display("field masks done");
    t_dma_clk();
    $display("dma and clock codes done");
    t_base();
    $display("base windows done");
    t_irq();
    $display("interrupt done");
    t_ir(1'b0);
    t_ir(1'b1);
    $display("infrared turnaround done");
    conclude();
  end
endmodule // spcr_regs_test
